// file: core/dls_ctrl.v
// control state machine of the dual input load switch
`include "dls_defs.vh"
`default_nettype none
// Behaviour
// - overvoltage opens the switch directly, state machine untouched
// - level select grounded picks high trip level, floating picks low
// - autonomous mode closes or opens switch on valid input supply
// - receiver enable output low while no input supply present, except in the OTG on and OTG discharge states
// - receiver enable released high once input supply detected
// - output discharged before switch closes on valid input, break before make
// - input removal powers down and returns receiver enable low
// - flag pin driven low in normal operation
// - flag released when valid output and no valid input
// - system pulls flag low, switch closes, receiver enable high
// - system releases flag, switch opens, receiver enable low after discharge time
// - slave mode switch follows debounced enable pin
// - slave mode drives receiver enable and flag as autonomous mode
// - concurrent mode with regulated output holds receiver enable low
// - off state when neither supply above lockout
// - enable and disable recognised after debounce times, except the mode choice on leaving init
// - valid input after input debounce, output voltage ignored
// - valid output after output debounce and no valid input
// - output discharged as soon as below lockout, no debounce
// - flag low while released is enable, release high is disable
// - input debounce and discharge time 50 ms each
// - enable and flag debounce times 40 us each
// - output debounce time 40 us
// - enable high in autonomous state exits to slave ready, or to OTG slave ready from OTG ready
module dls_ctrl #(
  parameter DEBIN_CYC = `DLS_CYC_MS(`DLS_T_DEBIN_MS),
  parameter DIS_CYC = `DLS_CYC_MS(`DLS_T_DIS_MS),
  parameter INIT_CYC = `DLS_CYC_US(`DLS_T_INIT_US),
  parameter EN_CYC = `DLS_CYC_US(`DLS_T_EN_US),
  parameter FL_CYC = `DLS_CYC_US(`DLS_T_FL_US),
  parameter DEBOUT_CYC = `DLS_CYC_US(`DLS_T_DEBOUT_US)
) (
  input wire clk,
  input wire reset,
  input wire in_uvlo_ok,
  input wire out_uvlo_ok,
  input wire ovp_hi_trip,
  input wire ovp_lo_trip,
  input wire ovp_level_select,
  input wire enable_n,
  input wire flag_n_in,
  input wire concurrent_otg,
  output reg switch_on_reg,
  output reg discharge_reg,
  output reg rx_n_out_reg,
  output reg rx_n_oe_n_reg,
  output reg flag_n_out_reg,
  output reg flag_n_oe_n_reg,
  output reg [3:0] state_reg
);
  localparam CW = `DLS_CW;
  // two flip-flop synchronisers; stage one read only by stage two
  reg [5:0] s1_reg;
  reg [5:0] s2_reg;
  always @(posedge clk) begin
    if (reset) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
    end else begin
      s1_reg <= {concurrent_otg, flag_n_in, enable_n, ovp_level_select,
                 out_uvlo_ok, in_uvlo_ok};
      s2_reg <= s1_reg;
    end
  end
  wire in_ok = s2_reg[0];
  wire out_ok = s2_reg[1];
  wire en_n_s = s2_reg[3];
  wire flag_s = s2_reg[4];
  wire conc_s = s2_reg[5];
  // core runs while either supply clears lockout
  wire powered = in_ok | out_ok;

  // level select gets a third stage so a new setting never acts before the trip inputs
  reg s1_lvl_reg;
  reg s1_hi_reg;
  reg s1_lo_reg;
  reg s2_hi_reg;
  reg s2_lo_reg;
  always @(posedge clk) begin
    if (reset) begin
      s1_lvl_reg <= 1'b0;
      s1_hi_reg <= 1'b0;
      s1_lo_reg <= 1'b0;
      s2_hi_reg <= 1'b0;
      s2_lo_reg <= 1'b0;
    end else begin
      s1_lvl_reg <= s2_reg[2];
      s1_hi_reg <= ovp_hi_trip;
      s1_lo_reg <= ovp_lo_trip;
      s2_hi_reg <= s1_hi_reg;
      s2_lo_reg <= s1_lo_reg;
    end
  end
  wire lvl_s = s1_lvl_reg;
  // floating pin reads high through its pull-up: low threshold
  wire ovp = lvl_s ? s2_lo_reg : s2_hi_reg;

  // debouncer: counter clears whenever the raw level matches the held one and counts while it differs
  function [CW-1:0] deb_cnt;
    input raw;
    input held;
    input [CW-1:0] cnt;
    begin
      if (raw == held)
        deb_cnt = {CW{1'b0}};
      else
        deb_cnt = cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  reg [CW-1:0] cin_reg;
  reg [CW-1:0] cout_reg;
  reg [CW-1:0] cen_reg;
  reg [CW-1:0] cfl_reg;
  reg vin_reg;
  reg vout_raw_reg;
  reg en_reg;
  reg fl_reg;
  // flag low counts only while the device releases the pin
  wire fl_raw = ~flag_s & flag_n_oe_n_reg;
  always @(posedge clk) begin
    if (reset) begin
      cin_reg <= {CW{1'b0}};
      cout_reg <= {CW{1'b0}};
      cen_reg <= {CW{1'b0}};
      cfl_reg <= {CW{1'b0}};
      vin_reg <= 1'b0;
      vout_raw_reg <= 1'b0;
      en_reg <= 1'b0;
      fl_reg <= 1'b0;
    end else if (!powered) begin
      // core unpowered: debounce history is lost with it
      cin_reg <= {CW{1'b0}};
      cout_reg <= {CW{1'b0}};
      cen_reg <= {CW{1'b0}};
      cfl_reg <= {CW{1'b0}};
      vin_reg <= 1'b0;
      vout_raw_reg <= 1'b0;
      en_reg <= 1'b0;
      fl_reg <= 1'b0;
    end else begin
      cin_reg <= deb_cnt(in_ok, vin_reg, cin_reg);
      if (in_ok != vin_reg && cin_reg == DEBIN_CYC[CW-1:0] - 1'b1)
        vin_reg <= in_ok;
      cout_reg <= deb_cnt(out_ok, vout_raw_reg, cout_reg);
      if (out_ok != vout_raw_reg && cout_reg == DEBOUT_CYC[CW-1:0] - 1'b1)
        vout_raw_reg <= out_ok;
      cen_reg <= deb_cnt(~en_n_s, en_reg, cen_reg);
      if ((~en_n_s) != en_reg && cen_reg == EN_CYC[CW-1:0] - 1'b1)
        en_reg <= ~en_n_s;
      cfl_reg <= deb_cnt(fl_raw, fl_reg, cfl_reg);
      if (fl_raw != fl_reg && cfl_reg == FL_CYC[CW-1:0] - 1'b1)
        fl_reg <= fl_raw;
    end
  end
  wire vout = vout_raw_reg & ~vin_reg;
  wire out_dis = ~out_ok;

  function on_state;
    input [3:0] s;
    begin
      on_state = s == `DLS_ST_AUTO_ON || s == `DLS_ST_OTG_ON ||
                 s == `DLS_ST_SLV_ON || s == `DLS_ST_OTG_SLV_ON;
    end
  endfunction

  function disch_state;
    input [3:0] s;
    begin
      disch_state = s == `DLS_ST_AUTO_DISCH || s == `DLS_ST_OTG_DISCH ||
                    s == `DLS_ST_SLV_DISCH || s == `DLS_ST_OTG_SLV_DISCH;
    end
  endfunction

  // the flag stays released in the OTG on states so the system's pull keeps the switch closed
  function flag_rel_state;
    input [3:0] s;
    begin
      flag_rel_state = s == `DLS_ST_OTG_READY || s == `DLS_ST_OTG_ON ||
                       s == `DLS_ST_OTG_DISCH || s == `DLS_ST_OTG_SLV_READY ||
                       s == `DLS_ST_OTG_SLV_ON || s == `DLS_ST_OTG_SLV_DISCH;
    end
  endfunction

  function rx_low_state;
    input [3:0] s;
    begin
      rx_low_state = s == `DLS_ST_OFF || s == `DLS_ST_INIT ||
                     s == `DLS_ST_AUTO_READY || s == `DLS_ST_SLV_READY ||
                     s == `DLS_ST_OTG_READY || s == `DLS_ST_OTG_SLV_READY;
    end
  endfunction

  reg [3:0] st_next;
  reg [CW-1:0] t_reg;
  reg slave_reg;
  wire t_done = (t_reg >= DIS_CYC[CW-1:0] - 1'b1);
  wire i_done = (t_reg >= INIT_CYC[CW-1:0] - 1'b1);
  always @* begin
    st_next = state_reg;
    case (state_reg)
      `DLS_ST_OFF: begin
        if (powered)
          st_next = `DLS_ST_INIT;
      end
      `DLS_ST_INIT: begin
        if (i_done)
          st_next = en_n_s ? `DLS_ST_SLV_READY : `DLS_ST_AUTO_READY;
      end
      `DLS_ST_AUTO_READY: begin
        if (vin_reg) st_next = `DLS_ST_AUTO_DISCH;
        else if (vout) st_next = `DLS_ST_OTG_READY;
      end
      `DLS_ST_AUTO_DISCH: begin
        if (!vin_reg) st_next = `DLS_ST_AUTO_READY;
        else if (t_done && out_dis) st_next = `DLS_ST_AUTO_ON;
      end
      `DLS_ST_AUTO_ON: begin
        if (!vin_reg) st_next = `DLS_ST_AUTO_READY;
      end
      `DLS_ST_OTG_READY: begin
        if (vin_reg) st_next = `DLS_ST_AUTO_DISCH;
        else if (!vout) st_next = `DLS_ST_AUTO_READY;
        else if (fl_reg) st_next = `DLS_ST_OTG_ON;
      end
      `DLS_ST_OTG_ON: begin
        if (!fl_reg) st_next = `DLS_ST_OTG_DISCH;
      end
      `DLS_ST_OTG_DISCH: begin
        if (t_done) st_next = `DLS_ST_OTG_READY;
      end
      `DLS_ST_SLV_READY: begin
        if (en_reg && vin_reg) st_next = `DLS_ST_SLV_DISCH;
        else if (vout) st_next = `DLS_ST_OTG_SLV_READY;
      end
      `DLS_ST_SLV_DISCH: begin
        if (!en_reg || !vin_reg) st_next = `DLS_ST_SLV_READY;
        else if (t_done && out_dis) st_next = `DLS_ST_SLV_ON;
      end
      `DLS_ST_SLV_ON: begin
        if (!en_reg || !vin_reg) st_next = `DLS_ST_SLV_READY;
      end
      `DLS_ST_OTG_SLV_READY: begin
        if (vin_reg || !vout) st_next = `DLS_ST_SLV_READY;
        else if (en_reg || fl_reg) st_next = `DLS_ST_OTG_SLV_ON;
      end
      `DLS_ST_OTG_SLV_ON: begin
        if (!en_reg && !fl_reg) st_next = `DLS_ST_OTG_SLV_DISCH;
      end
      `DLS_ST_OTG_SLV_DISCH: begin
        if (t_done) st_next = `DLS_ST_OTG_SLV_READY;
      end
      default: begin
        st_next = `DLS_ST_OFF;
      end
    endcase
    // disable in an autonomous state leaves for slave ready, or for OTG slave ready from OTG ready
    if (!slave_reg && state_reg != `DLS_ST_OFF && state_reg != `DLS_ST_INIT
        && !en_reg && en_n_s && cen_reg == {CW{1'b0}}) begin
      if (state_reg == `DLS_ST_OTG_READY)
        st_next = `DLS_ST_OTG_SLV_READY;
      else
        st_next = `DLS_ST_SLV_READY;
    end
    if (!powered)
      st_next = `DLS_ST_OFF;
  end


  // discharge, receiver and flag pins follow the next state so they move on the same edge as the state
  wire sw_st = on_state(state_reg);
  wire dis_st = disch_state(st_next);
  wire rel_flag = flag_rel_state(st_next);
  wire rx_high = ~rx_low_state(st_next);
  always @(posedge clk) begin
    if (reset) begin
      state_reg <= `DLS_ST_OFF;
      t_reg <= {CW{1'b0}};
      slave_reg <= 1'b0;
      switch_on_reg <= 1'b0;
      discharge_reg <= 1'b0;
      rx_n_out_reg <= 1'b0;
      rx_n_oe_n_reg <= 1'b0;
      flag_n_out_reg <= 1'b0;
      flag_n_oe_n_reg <= 1'b0;
    end else begin
      state_reg <= st_next;
      t_reg <= (st_next != state_reg) ? {CW{1'b0}} : t_reg + {{(CW-1){1'b0}}, 1'b1};
      slave_reg <= st_next >= `DLS_ST_SLV_READY;
      // overvoltage gates only the switch drive, never the state
      switch_on_reg <= sw_st & (st_next == state_reg) & ~ovp;
      discharge_reg <= dis_st;
      rx_n_out_reg <= 1'b0;
      // released means pulled up; concurrent mode forces it low
      rx_n_oe_n_reg <= rx_high & ~conc_s;
      flag_n_out_reg <= 1'b0;
      flag_n_oe_n_reg <= rel_flag;
    end
  end
endmodule
`default_nettype wire

// file: core/dls_defs.vh
// constants for the dual input load switch controller
`ifndef DLS_DEFS_VH
`define DLS_DEFS_VH
`define DLS_CLK_KHZ 125000
`define DLS_T_DEBIN_MS 50
`define DLS_T_DIS_MS 50
`define DLS_T_EN_US 40
`define DLS_T_FL_US 40
`define DLS_T_DEBOUT_US 40
`define DLS_T_INIT_US 150
`define DLS_CYC_MS(t) ((t) * `DLS_CLK_KHZ)
`define DLS_CYC_US(t) ((t) * `DLS_CLK_KHZ / 1000)
`define DLS_CW 24
`define DLS_ST_OFF 4'h0
`define DLS_ST_INIT 4'h1
`define DLS_ST_AUTO_READY 4'h2
`define DLS_ST_AUTO_DISCH 4'h3
`define DLS_ST_AUTO_ON 4'h4
`define DLS_ST_OTG_READY 4'h5
`define DLS_ST_OTG_ON 4'h6
`define DLS_ST_OTG_DISCH 4'h7
`define DLS_ST_SLV_READY 4'h8
`define DLS_ST_SLV_DISCH 4'h9
`define DLS_ST_SLV_ON 4'ha
`define DLS_ST_OTG_SLV_READY 4'hb
`define DLS_ST_OTG_SLV_ON 4'hc
`define DLS_ST_OTG_SLV_DISCH 4'hd
`endif

// file: testbench/dls_ctrl_asserts.sv
// concurrent checks on the load switch controller ports
`include "dls_defs.vh"
`default_nettype none
module dls_ctrl_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_uvlo_ok,
  input wire logic out_uvlo_ok,
  input wire logic ovp_hi_trip,
  input wire logic ovp_lo_trip,
  input wire logic ovp_level_select,
  input wire logic concurrent_otg,
  input wire logic switch_on_reg,
  input wire logic rx_n_out_reg,
  input wire logic rx_n_oe_n_reg,
  input wire logic flag_n_out_reg,
  input wire logic flag_n_oe_n_reg,
  input wire logic [3:0] state_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire on_st = state_reg == `DLS_ST_AUTO_ON || state_reg == `DLS_ST_OTG_ON ||
    state_reg == `DLS_ST_SLV_ON || state_reg == `DLS_ST_OTG_SLV_ON;
  ovp_hi_open_a: assert property (
    (ovp_hi_trip && !ovp_level_select)[*5] |-> !switch_on_reg)
    else $error("switch closed at high trip");
  ovp_lo_open_a: assert property (
    (ovp_lo_trip && ovp_level_select)[*5] |-> !switch_on_reg)
    else $error("switch closed at low trip");
  off_state_a: assert property (
    (!in_uvlo_ok && !out_uvlo_ok)[*6] |-> state_reg == `DLS_ST_OFF)
    else $error("not off without supply");
  make_order_a: assert property (
    $changed(state_reg) && state_reg == `DLS_ST_AUTO_ON |->
    $past(state_reg) == `DLS_ST_AUTO_DISCH)
    else $error("closed without discharge");
  switch_state_a: assert property (
    switch_on_reg |-> on_st || $past(on_st))
    else $error("switch closed outside on state");
  pins_low_a: assert property (
    rx_n_out_reg == 1'b0 && flag_n_out_reg == 1'b0)
    else $error("pin driven high");
  flag_release_a: assert property (
    (state_reg == `DLS_ST_OTG_READY)[*2] |-> flag_n_oe_n_reg)
    else $error("flag not released");
  auto_on_pins_a: assert property (
    (state_reg == `DLS_ST_AUTO_ON && !concurrent_otg)[*2] |->
    rx_n_oe_n_reg && !flag_n_oe_n_reg)
    else $error("pins wrong when on");
  rx_ready_a: assert property (
    (state_reg == `DLS_ST_AUTO_READY)[*2] |-> !rx_n_oe_n_reg)
    else $error("receiver disabled in ready");
  concurrent_rx_a: assert property (
    concurrent_otg[*4] |-> !rx_n_oe_n_reg)
    else $error("receiver disabled in concurrent mode");
  cover property (state_reg == `DLS_ST_AUTO_ON);
  cover property (state_reg == `DLS_ST_OTG_ON);
  cover property (ovp_hi_trip && !switch_on_reg);
endmodule
bind dls_ctrl dls_ctrl_asserts dls_ctrl_asserts_i (.*);
`default_nettype wire

// file: testbench/dls_ctrl_tb.sv
// self-checking bench for the load switch controller
`include "dls_defs.vh"
`default_nettype none
module dls_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DB = 200;
  localparam int SH = 20;
  logic clk, reset, in_uvlo_ok, out_uvlo_ok, ovp_hi_trip, ovp_lo_trip, ovp_level_select;
  logic enable_n, flag_n_in, concurrent_otg, sys_pull, switch_on_reg, discharge_reg;
  logic rx_n_out_reg, rx_n_oe_n_reg, flag_n_out_reg, flag_n_oe_n_reg;
  logic [3:0] state_reg;
  int fails, comparisons, n, t;
  // short counts keep the run small; all expectations derive from DB and SH
  dls_ctrl #(.DEBIN_CYC(DB), .DIS_CYC(DB), .INIT_CYC(SH), .EN_CYC(SH), .FL_CYC(SH),
    .DEBOUT_CYC(SH)) dls_ctrl_i (.*);
  dls_sys_model dls_sys_model_i (.*);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (state_reg !== s && n < lim);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic t_auto;
    @(posedge clk) in_uvlo_ok <= 1'b1;
    wait_st(`DLS_ST_AUTO_READY, 100);
    t = n;
    check("rx_oe", rx_n_oe_n_reg, 4'h0);
    wait_st(`DLS_ST_AUTO_DISCH, 1000);
    check("debounce", t + n >= DB - 1 && t + n <= DB + 8, 4'h1);
    check("rx_oe", rx_n_oe_n_reg, 4'h1);
    check("disch", discharge_reg, 4'h1);
    wait_st(`DLS_ST_AUTO_ON, 1000);
    check("disch time", n >= DB - 1 && n <= DB + 4, 4'h1);
    cyc(2);
    check("switch", switch_on_reg, 4'h1);
    @(posedge clk) ovp_hi_trip <= 1'b1;
    cyc(6);
    check("switch", switch_on_reg, 4'h0);
    check("state", state_reg, `DLS_ST_AUTO_ON);
    @(posedge clk) {ovp_hi_trip, ovp_lo_trip} <= 2'h1;
    cyc(8);
    check("switch", switch_on_reg, 4'h1);
    @(posedge clk) {ovp_lo_trip, in_uvlo_ok} <= 2'h0;
    wait_st(`DLS_ST_OFF, 300);
    check("state", state_reg, `DLS_ST_OFF);
    check("rx_oe", rx_n_oe_n_reg, 4'h0);
  endtask
  task automatic t_otg;
    @(posedge clk) out_uvlo_ok <= 1'b1;
    wait_st(`DLS_ST_OTG_READY, 200);
    check("flag", flag_n_in, 4'h1);
    @(posedge clk) sys_pull <= 1'b1;
    wait_st(`DLS_ST_OTG_ON, 200);
    cyc(2);
    check("switch", switch_on_reg, 4'h1);
    check("rx_oe", rx_n_oe_n_reg, 4'h1);
    @(posedge clk) concurrent_otg <= 1'b1;
    cyc(6);
    check("rx_oe", rx_n_oe_n_reg, 4'h0);
    @(posedge clk) {concurrent_otg, sys_pull} <= 2'h0;
    wait_st(`DLS_ST_OTG_DISCH, 200);
    check("switch", switch_on_reg, 4'h0);
    wait_st(`DLS_ST_OTG_READY, 1000);
    check("rx_oe", rx_n_oe_n_reg, 4'h0);
    @(posedge clk) enable_n <= 1'b1;
    wait_st(`DLS_ST_OTG_SLV_READY, 200);
    check("state", state_reg, `DLS_ST_OTG_SLV_READY);
    @(posedge clk) out_uvlo_ok <= 1'b0;
    wait_st(`DLS_ST_OFF, 300);
  endtask
  task automatic t_slave;
    @(posedge clk) in_uvlo_ok <= 1'b1;
    wait_st(`DLS_ST_SLV_READY, 200);
    check("state", state_reg, `DLS_ST_SLV_READY);
    @(posedge clk) enable_n <= 1'b0;
    wait_st(`DLS_ST_SLV_ON, 1000);
    check("en debounce", n >= SH, 4'h1);
    cyc(2);
    check("switch", switch_on_reg, 4'h1);
    check("rx_oe", rx_n_oe_n_reg, 4'h1);
    check("flag_oe", flag_n_oe_n_reg, 4'h0);
    @(posedge clk) {ovp_level_select, ovp_lo_trip} <= 2'h3;
    cyc(6);
    check("switch", switch_on_reg, 4'h0);
    @(posedge clk) {ovp_hi_trip, ovp_lo_trip} <= 2'h2;
    cyc(8);
    check("switch", switch_on_reg, 4'h1);
    @(posedge clk) {ovp_level_select, ovp_hi_trip} <= 2'h0;
    cyc(6);
    @(posedge clk) enable_n <= 1'b1;
    wait_st(`DLS_ST_SLV_READY, 300);
    check("switch", switch_on_reg, 4'h0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {reset, in_uvlo_ok, out_uvlo_ok, ovp_hi_trip, ovp_lo_trip} = 5'h10;
    {ovp_level_select, enable_n, concurrent_otg, sys_pull} = 4'h0;
    cyc(20);
    check("reset", {switch_on_reg, discharge_reg, rx_n_oe_n_reg, flag_n_oe_n_reg}, 4'h0);
    check("state", state_reg, `DLS_ST_OFF);
    @(posedge clk) reset <= 1'b0;
    t_auto();
    t_otg();
    t_slave();
    complete_run();
  end
  // stalls past about twenty times the expected span count as a mismatch
  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: testbench/dls_sys_model.sv
// system side of the flag pin: on-chip pull-up plus the system pull-down
`default_nettype none
module dls_sys_model (
  input wire logic flag_n_out_reg,
  input wire logic flag_n_oe_n_reg,
  input wire logic sys_pull,
  output logic flag_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin floats up, so the system can only ever pull it down
  assign flag_n_in = (flag_n_oe_n_reg ? 1'b1 : flag_n_out_reg) & ~sys_pull;
endmodule
`default_nettype wire
